// File: tb.sv
/* Self-checking bench for the timer-window comparator gate.
   Assumes a short PWM period parameter; APB waits end on PREADY, and a stuck one only at the cycle timeout. */
`timescale 1ns/1ns
`define CHK(n, e, s) begin comparisons++; if ((s) !== (e)) begin err_total++; \
	$display("wrong value %s exp %0h got %0h", n, e, s); end end
module tb;
	localparam logic [15:0] PER = 16'h0064;
	localparam int DUTY = 30;
	localparam int DL = 5;
	localparam int WD = 20;
	logic clk, rst_n, psel, pen, pwr, pslverr, pready, pwm, win, gated, dpin, rerr, clk_en;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdat;
	logic [9:0] lvl, smp;
	int err_total, comparisons, cyc, gh, dly, wid, r, i, e, k;
	twg_gate #(.P_PERIOD_CYC(PER)) dut (.CORE_CLK(clk), .RST_N(rst_n), .CLK_EN(clk_en),
		.PSEL(psel), .PENABLE(pen), .PWRITE(pwr), .PADDR(paddr), .PWDATA(pwdata),
		.PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CMP_ANALOG_INPUT(smp),
		.PWM_OUT_B0(pwm), .WINDOW_PULSE_OUT(win), .GATED_CMP_RESULT_PIN(gated),
		.DAC_PIN_EN(dpin));
	twg_analog_src src (.clk(clk), .level(lvl), .sample(smp));
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task give_verdict;
		if (err_total == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (gated === 1'b1) begin
			`CHK("window", 1'b1, win)
		end
		if (cyc == 20000) begin
			err_total++;
			give_verdict();
		end
	end
	// Starts one edge after the last release so no signal is assigned twice at once.
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask
	task chk_rd(input logic [7:0] a, input logic [31:0] x, input string n);
		apb(1'b0, a, 32'h0);
		`CHK(n, x, rdat)
	endtask
	task edge_wait(input logic t);
		logic a, b;
		int n;
		b = pwm;
		for (n = 0; n < 400; n++) begin
			a = b;
			@(posedge clk);
			b = pwm;
			if (b === t && a !== t)
				break;
		end
	endtask
	task meas(input logic t);
		edge_wait(t);
		gh = 0;
		dly = 0;
		while (win !== 1'b1 && dly < 300) begin
			@(posedge clk);
			dly++;
		end
		wid = 0;
		while (win === 1'b1 && wid < 300) begin
			if (gated === 1'b1)
				gh++;
			@(posedge clk);
			wid++;
		end
		#1;
	endtask
	function automatic logic [31:0] ctl(input int ed, input int f, input logic m);
		return {23'h0, 1'b0, f[1:0], ed[1:0], m, 3'h7};
	endfunction
	// A disabled edge leaves the window to the next enabled edge of the other kind.
	function automatic int exp_d(input int ed, input int t);
		return (t ? ed[0] : ed[1]) ? DL + 1 : DL + 1 + (t ? DUTY : PER - DUTY);
	endfunction
	initial begin
		r = $urandom(32'hA44965FA);
		rst_n = 1'b0;
		clk_en = 1'b1;
		psel = 1'b0;
		pen = 1'b0;
		pwr = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		lvl = 10'h000;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		`CHK("dac pin", 1'b0, dpin)
		chk_rd(twg_pkg::OFS_CTRL, 32'h0000001F, "ctrl");
		chk_rd(twg_pkg::OFS_DAC, 32'h00000200, "dac");
		chk_rd(twg_pkg::OFS_DELAY, 32'h000000FA, "delay");
		chk_rd(twg_pkg::OFS_WIDTH, 32'h000009C4, "width");
		chk_rd(twg_pkg::OFS_PERIOD, 32'h00000064, "period");
		chk_rd(twg_pkg::OFS_DUTY, 32'h0000001E, "duty");
		r = $urandom();
		apb(1'b1, twg_pkg::OFS_GEN_C, r);
		chk_rd(twg_pkg::OFS_GEN_C, r, "gen c");
		chk_rd(8'h3C, 32'h0, "unmapped");
		`CHK("slverr", 1'b1, rerr)
		edge_wait(1'b1);
		wid = 0;
		while (pwm === 1'b1 && wid < 300) begin
			@(posedge clk);
			wid++;
		end
		dly = 0;
		while (pwm !== 1'b1 && dly < 300) begin
			@(posedge clk);
			dly++;
		end
		`CHK("pwm high", DUTY, wid)
		`CHK("pwm period", PER, wid + dly)
		apb(1'b1, twg_pkg::OFS_DELAY, DL);
		apb(1'b1, twg_pkg::OFS_WIDTH, WD);
		for (e = 1; e < 4; e++) begin
			apb(1'b1, twg_pkg::OFS_CTRL, ctl(e, 0, 1'b1));
			for (k = 0; k < 2; k++) begin
				meas(k[0]);
				meas(k[0]);
				`CHK("delay", exp_d(e, k), dly)
				`CHK("width", WD, wid)
			end
		end
		for (i = 0; i < 7; i++) begin
			r = (i < 2) ? 512 : $urandom_range(1022, 0);
			apb(1'b1, twg_pkg::OFS_DAC, r);
			apb(1'b1, twg_pkg::OFS_CTRL, ctl(1, i / 2 % 3, i != 6));
			lvl <= r[9:0] + 10'(i % 2 == 0);
			repeat (40) @(posedge clk);
			meas(1'b1);
			meas(1'b1);
			`CHK("gated", (i % 2 == 0 && i != 6) ? WD : 0, gh)
			`CHK("win", WD, wid)
		end
		apb(1'b0, twg_pkg::OFS_STATUS, 32'h0);
		`CHK("filtered", 1'b1, rdat[twg_pkg::ST_FILT])
		`CHK("rise flag", 1'b1, rdat[twg_pkg::ST_RISE])
		apb(1'b1, twg_pkg::OFS_STATUS, 32'h00000010);
		apb(1'b0, twg_pkg::OFS_STATUS, 32'h0);
		`CHK("rise clear", 1'b0, rdat[twg_pkg::ST_RISE])
		r = $urandom();
		apb(1'b1, twg_pkg::OFS_GEN_D, r);
		chk_rd(twg_pkg::OFS_GEN_D, r, "gen d");
		apb(1'b1, twg_pkg::OFS_CTRL, 32'h00000100 | ctl(1, 0, 1'b1));
		@(posedge clk);
		`CHK("dac pin on", 1'b1, dpin)
		// The enable stays low longer than either PWM phase, so a running counter would show.
		clk_en <= 1'b0;
		@(posedge clk);
		r = pwm;
		repeat (80) @(posedge clk);
		`CHK("ready", 1'b0, pready)
		`CHK("frozen", r[0], pwm)
		clk_en <= 1'b1;
		give_verdict();
	end
endmodule // tb

// File: twg_analog_src.sv
/* Behavioural source for the comparator input sample.
   Assumes the bench sets a level and the core clock samples it. */
`timescale 1ns/1ns
module twg_analog_src (
	// Clock.
	input wire logic clk,
	// Requested level and sampled code.
	input wire logic [9:0] level,
	output logic [9:0] sample
);
	// One cycle of lag stands in for the settling of a real input.
	always_ff @(posedge clk) begin
		sample <= level;
	end
endmodule // twg_analog_src

// File: twg_gate.sv
/*
 * Timer-window comparator gate: PWM timer, delayed one-shot window, reference
 * converter code, filtered comparator and the gated result pin, behind APB.
 * Assumes all inputs synchronous to CORE_CLK; the analog input arrives as a sample code.
 */
// How it works
// - The gated result pin is low whenever the window pulse is low.
// - The one-shot start is taken from the PWM output on its rising, falling or both edges.
// - The PWM output runs a 300 us period with 30 percent high time by default.
// - On each trigger taken while idle the one-shot waits 10 us and then holds the window high for 100 us.
// - The window output starts at zero and is high only during the width interval.
// - A master phase times the delay and a slave phase times the width and drives the window.
// - Delay and width counts are derived from the core clock standing in for the peripheral clock.
// - Period and duty counts are derived from the core clock standing in for the PWM count clock.
// - The PWM counter wraps on the period match and the C and D registers are plain storage.
// - The PWM output starts inactive, is active high and has no cutoff and no interrupt.
// - The reference code is 10 bits, reset to 512, with its analog pin output disabled.
// - The comparator compares against the reference, flags rising edges and filters by a chosen clock.
// - The result reaches its pin only in window output mode, and no interrupt exists.
`timescale 1ns/1ns
module twg_gate #(
	parameter logic [15:0] P_PERIOD_CYC = 16'(twg_pkg::PWM_PERIOD_CYC)
) (
	// Clock, reset and enable.
	input wire logic CORE_CLK,
	input wire logic RST_N,
	input wire logic CLK_EN,
	// APB slave.
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Comparator input sample.
	input wire logic [9:0] CMP_ANALOG_INPUT,
	// Pins.
	output logic PWM_OUT_B0,
	output logic WINDOW_PULSE_OUT,
	output logic GATED_CMP_RESULT_PIN,
	output logic DAC_PIN_EN
);

	localparam logic [15:0] DUTY_RST = 16'((32'(P_PERIOD_CYC) * twg_pkg::PWM_DUTY_PCT) / 100);
	localparam logic [15:0] ONE = 16'h0001;

	logic [8:0] ctrl_q;
	logic [15:0] period_q;
	logic [15:0] duty_q;
	logic [15:0] delay_q;
	logic [15:0] width_q;
	logic [9:0] dac_q;
	logic [31:0] gen_c_q;
	logic [31:0] gen_d_q;
	logic [31:0] prdata_q;
	logic [15:0] pwm_cnt_q;
	logic pwm_q;
	logic pwm_prev_q;
	logic [15:0] os_cnt_q;
	twg_pkg::twg_os_state_t os_state_q;
	twg_pkg::twg_os_state_t os_state_d;
	logic [15:0] os_cnt_d;
	logic raw_q;
	logic [2:0] filt_sh_q;
	logic filt_q;
	logic filt_d;
	logic filt_prev_q;
	logic rise_q;
	logic [1:0] div_q;
	logic gated_q;

	// Bus decode.
	wire setup = PSEL & ~PENABLE;
	wire access = PSEL & PENABLE & CLK_EN;
	wire wr = access & PWRITE;
	wire hit_ctrl = PADDR == twg_pkg::OFS_CTRL;
	wire hit_period = PADDR == twg_pkg::OFS_PERIOD;
	wire hit_duty = PADDR == twg_pkg::OFS_DUTY;
	wire hit_delay = PADDR == twg_pkg::OFS_DELAY;
	wire hit_width = PADDR == twg_pkg::OFS_WIDTH;
	wire hit_dac = PADDR == twg_pkg::OFS_DAC;
	wire hit_status = PADDR == twg_pkg::OFS_STATUS;
	wire hit_gen_c = PADDR == twg_pkg::OFS_GEN_C;
	wire hit_gen_d = PADDR == twg_pkg::OFS_GEN_D;
	wire hit_any = hit_ctrl | hit_period | hit_duty | hit_delay | hit_width | hit_dac
		| hit_status | hit_gen_c | hit_gen_d;

	// Control fields.
	wire pwm_en = ctrl_q[twg_pkg::CTRL_PWM_EN];
	wire os_en = ctrl_q[twg_pkg::CTRL_OS_EN];
	wire cmp_en = ctrl_q[twg_pkg::CTRL_CMP_EN];
	wire win_mode = ctrl_q[twg_pkg::CTRL_WIN_MODE];
	wire [1:0] edge_sel = ctrl_q[twg_pkg::CTRL_EDGE_LO +: 2];
	wire [1:0] filt_sel = ctrl_q[twg_pkg::CTRL_FILT_LO +: 2];

	wire [31:0] status = {27'h0, rise_q, gated_q, filt_q, WINDOW_PULSE_OUT, pwm_q};

	wire [31:0] rd_mux = hit_ctrl ? {23'h0, ctrl_q} :
		hit_period ? {16'h0, period_q} :
		hit_duty ? {16'h0, duty_q} :
		hit_delay ? {16'h0, delay_q} :
		hit_width ? {16'h0, width_q} :
		hit_dac ? {22'h0, dac_q} :
		hit_status ? status :
		hit_gen_c ? gen_c_q :
		hit_gen_d ? gen_d_q : 32'h0;

	assign PREADY = CLK_EN;
	assign PSLVERR = PSEL & PENABLE & ~hit_any;
	assign PRDATA = prdata_q;

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			ctrl_q <= twg_pkg::CTRL_RST;
			period_q <= P_PERIOD_CYC;
			duty_q <= DUTY_RST;
			delay_q <= twg_pkg::DELAY_RST;
			width_q <= twg_pkg::WIDTH_RST;
			dac_q <= twg_pkg::DAC_RST[9:0];
			gen_c_q <= 32'h0;
			gen_d_q <= 32'h0;
			prdata_q <= 32'h0;
		end else if (CLK_EN) begin
			if (setup) begin
				prdata_q <= rd_mux;
			end
			if (wr && hit_ctrl) begin
				ctrl_q <= PWDATA[8:0];
			end
			if (wr && hit_period) begin
				period_q <= PWDATA[15:0];
			end
			if (wr && hit_duty) begin
				duty_q <= PWDATA[15:0];
			end
			if (wr && hit_delay) begin
				delay_q <= PWDATA[15:0];
			end
			if (wr && hit_width) begin
				width_q <= PWDATA[15:0];
			end
			if (wr && hit_dac) begin
				dac_q <= PWDATA[9:0];
			end
			// Plain storage: a write lands at once and is never transferred elsewhere.
			if (wr && hit_gen_c) begin
				gen_c_q <= PWDATA;
			end
			if (wr && hit_gen_d) begin
				gen_d_q <= PWDATA;
			end
		end
	end

	// PWM timer: free running, wraps on the period match, high while below the duty count.
	wire pwm_wrap = pwm_cnt_q >= period_q - ONE;
	wire [15:0] pwm_cnt_d = pwm_wrap ? 16'h0 : pwm_cnt_q + ONE;

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			pwm_cnt_q <= 16'h0;
			pwm_q <= 1'b0;
			pwm_prev_q <= 1'b0;
		end else if (CLK_EN) begin
			pwm_cnt_q <= pwm_en ? pwm_cnt_d : 16'h0;
			pwm_q <= pwm_en & (pwm_cnt_q < duty_q);
			pwm_prev_q <= pwm_q;
		end
	end

	assign PWM_OUT_B0 = pwm_q;

	// Start trigger from the selected PWM edge.
	wire pwm_rise = pwm_q & ~pwm_prev_q;
	wire pwm_fall = ~pwm_q & pwm_prev_q;
	wire os_trig = os_en & ((edge_sel[0] & pwm_rise) | (edge_sel[1] & pwm_fall));

	// One-shot: the delay phase is the master, the width phase the slave driving the window.
	// A trigger while a shot is running is ignored, so a short period never stretches it.
	wire delay_done = os_cnt_q >= delay_q - ONE;
	wire width_done = os_cnt_q >= width_q - ONE;

	always_comb begin
		os_state_d = os_state_q;
		os_cnt_d = os_cnt_q + ONE;
		case (os_state_q)
			twg_pkg::OS_IDLE: begin
				os_cnt_d = 16'h0;
				if (os_trig) begin
					os_state_d = twg_pkg::OS_DELAY;
				end
			end
			twg_pkg::OS_DELAY: begin
				if (delay_done) begin
					os_state_d = twg_pkg::OS_PULSE;
					os_cnt_d = 16'h0;
				end
			end
			twg_pkg::OS_PULSE: begin
				if (width_done) begin
					os_state_d = twg_pkg::OS_IDLE;
					os_cnt_d = 16'h0;
				end
			end
			default: begin
				os_state_d = twg_pkg::OS_IDLE;
				os_cnt_d = 16'h0;
			end
		endcase
		if (!os_en) begin
			os_state_d = twg_pkg::OS_IDLE;
			os_cnt_d = 16'h0;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			os_state_q <= twg_pkg::OS_IDLE;
			os_cnt_q <= 16'h0;
		end else if (CLK_EN) begin
			os_state_q <= os_state_d;
			os_cnt_q <= os_cnt_d;
		end
	end

	assign WINDOW_PULSE_OUT = os_state_q == twg_pkg::OS_PULSE;
	wire win_d = os_state_d == twg_pkg::OS_PULSE;

	// Comparator: sample above reference, then a three-sample majority-free agreement filter.
	// The slower filter sources are modelled as sampling strobes from one clock.
	wire samp = (filt_sel == twg_pkg::FILT_PERIPH) ? 1'b1 :
		(filt_sel == twg_pkg::FILT_PLL) ? div_q[0] :
		(filt_sel == twg_pkg::FILT_OSC) ? (div_q == 2'h3) : 1'b1;
	wire [2:0] filt_sh_d = samp ? {filt_sh_q[1:0], raw_q} : filt_sh_q;

	always_comb begin
		filt_d = filt_q;
		if (!cmp_en) begin
			filt_d = 1'b0;
		end else if (&filt_sh_d) begin
			filt_d = 1'b1;
		end else if (~|filt_sh_d) begin
			filt_d = 1'b0;
		end
	end

	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			raw_q <= 1'b0;
			filt_sh_q <= 3'h0;
			filt_q <= 1'b0;
			filt_prev_q <= 1'b0;
			rise_q <= 1'b0;
			div_q <= 2'h0;
			gated_q <= 1'b0;
		end else if (CLK_EN) begin
			div_q <= div_q + 2'h1;
			raw_q <= cmp_en & (CMP_ANALOG_INPUT > dac_q);
			filt_sh_q <= filt_sh_d;
			filt_q <= filt_d;
			filt_prev_q <= filt_q;
			// Rising-edge flag; a new edge wins over a write-one clear in the same cycle.
			if (filt_q && !filt_prev_q) begin
				rise_q <= 1'b1;
			end else if (wr && hit_status && PWDATA[twg_pkg::ST_RISE]) begin
				rise_q <= 1'b0;
			end
			// Built from next-state terms so the pin tracks the window with no lag.
			gated_q <= filt_d & win_d & win_mode;
		end
	end

	assign GATED_CMP_RESULT_PIN = gated_q;
	assign DAC_PIN_EN = ctrl_q[twg_pkg::CTRL_DAC_PIN];

	// Helper: cycles spent high in the current window pulse.
	logic [15:0] win_len_q;
	always_ff @(posedge CORE_CLK) begin
		if (!RST_N) begin
			win_len_q <= 16'h0;
		end else if (CLK_EN) begin
			win_len_q <= WINDOW_PULSE_OUT ? win_len_q + ONE : 16'h0;
		end
	end

	property p_gate_low;
		@(posedge CORE_CLK) disable iff (!RST_N) !WINDOW_PULSE_OUT |-> !GATED_CMP_RESULT_PIN;
	endproperty
	a_gate_low: assert property (p_gate_low) else $error("result high outside window");

	property p_trig;
		@(posedge CORE_CLK) disable iff (!RST_N)
			CLK_EN && os_state_q == twg_pkg::OS_IDLE && os_trig
			|=> os_state_q == twg_pkg::OS_DELAY;
	endproperty
	a_trig: assert property (p_trig) else $error("edge trigger not taken");

	property p_pwm_high;
		@(posedge CORE_CLK) disable iff (!RST_N)
			CLK_EN && pwm_en && pwm_cnt_q < duty_q |=> pwm_q;
	endproperty
	a_pwm_high: assert property (p_pwm_high) else $error("pwm low inside duty");

	property p_width;
		@(posedge CORE_CLK) disable iff (!RST_N)
			WINDOW_PULSE_OUT |-> win_len_q < width_q;
	endproperty
	a_width: assert property (p_width) else $error("window longer than width");

	property p_delay_first;
		@(posedge CORE_CLK) disable iff (!RST_N)
			$rose(WINDOW_PULSE_OUT) |-> $past(os_state_q) == twg_pkg::OS_DELAY;
	endproperty
	a_delay_first: assert property (p_delay_first) else $error("window without delay");

	// Not disabled by reset, because what reset leaves on the pins is the point here.
	property p_idle_low;
		@(posedge CORE_CLK)
			!RST_N |=> !WINDOW_PULSE_OUT && !PWM_OUT_B0 && !GATED_CMP_RESULT_PIN;
	endproperty
	a_idle_low: assert property (p_idle_low) else $error("output high after reset");

	property p_wrap;
		@(posedge CORE_CLK) disable iff (!RST_N)
			CLK_EN && pwm_en && pwm_wrap |=> pwm_cnt_q == 16'h0;
	endproperty
	a_wrap: assert property (p_wrap) else $error("pwm counter did not wrap");

	property p_mode;
		@(posedge CORE_CLK) disable iff (!RST_N)
			GATED_CMP_RESULT_PIN |-> $past(win_mode) && filt_q;
	endproperty
	a_mode: assert property (p_mode) else $error("result out of window mode");

	property p_and;
		@(posedge CORE_CLK) disable iff (!RST_N)
			CLK_EN ##1 1'b1 |-> GATED_CMP_RESULT_PIN == (filt_q && WINDOW_PULSE_OUT && $past(win_mode));
	endproperty
	a_and: assert property (p_and) else $error("gated result mismatch");

endmodule // twg_gate

// File: twg_pkg.sv
/*
 * Constants for the timer-window comparator gate: register map, field positions,
 * reset values, timing figures and one-shot states.
 * Assumes a single 25 MHz core clock from which every count is derived.
 */
package twg_pkg;

	// Core clock rate, and the documented source rates kept for reference.
	localparam int CORE_CLK_HZ = 25_000_000;
	localparam int PWM_COUNT_CLOCK_HZ = 96_000_000;
	localparam int PERIPHERAL_CLOCK_HZ = 48_000_000;
	localparam int CLK_PER_US = CORE_CLK_HZ / 1_000_000;

	// Times in microseconds and percent, and counts derived from them.
	localparam int PWM_PERIOD_US = 300;
	localparam int PWM_DUTY_PCT = 30;
	localparam int OS_DELAY_US = 10;
	localparam int OS_WIDTH_US = 100;
	localparam int PWM_PERIOD_CYC = PWM_PERIOD_US * CLK_PER_US;
	localparam int OS_DELAY_CYC = OS_DELAY_US * CLK_PER_US;
	localparam int OS_WIDTH_CYC = OS_WIDTH_US * CLK_PER_US;

	// Widths.
	localparam int CNT_W = 16;
	localparam int DAC_W = 10;
	localparam int ADDR_W = 8;

	// Register byte offsets.
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_PERIOD = 8'h04;
	localparam logic [7:0] OFS_DUTY = 8'h08;
	localparam logic [7:0] OFS_DELAY = 8'h0C;
	localparam logic [7:0] OFS_WIDTH = 8'h10;
	localparam logic [7:0] OFS_DAC = 8'h14;
	localparam logic [7:0] OFS_STATUS = 8'h18;
	localparam logic [7:0] OFS_GEN_C = 8'h1C;
	localparam logic [7:0] OFS_GEN_D = 8'h20;

	// Control fields.
	localparam int CTRL_PWM_EN = 0;
	localparam int CTRL_OS_EN = 1;
	localparam int CTRL_CMP_EN = 2;
	localparam int CTRL_WIN_MODE = 3;
	localparam int CTRL_EDGE_LO = 4;
	localparam int CTRL_FILT_LO = 6;
	localparam int CTRL_DAC_PIN = 8;
	localparam int CTRL_W = 9;
	localparam logic [8:0] CTRL_RST = 9'h01F;

	// Edge select and filter clock select codes.
	localparam logic [1:0] EDGE_RISE = 2'h1;
	localparam logic [1:0] EDGE_FALL = 2'h2;
	localparam logic [1:0] FILT_PERIPH = 2'h0;
	localparam logic [1:0] FILT_PLL = 2'h1;
	localparam logic [1:0] FILT_OSC = 2'h2;
	localparam int FILT_TAPS = 3;

	// Status fields.
	localparam int ST_PWM = 0;
	localparam int ST_WIN = 1;
	localparam int ST_FILT = 2;
	localparam int ST_GATED = 3;
	localparam int ST_RISE = 4;

	// Reset values.
	localparam logic [15:0] DAC_RST = 16'h0200;
	localparam logic [15:0] DELAY_RST = 16'(OS_DELAY_CYC);
	localparam logic [15:0] WIDTH_RST = 16'(OS_WIDTH_CYC);

	typedef enum logic [2:0] {
		OS_IDLE = 3'h1,
		OS_DELAY = 3'h2,
		OS_PULSE = 3'h4
	} twg_os_state_t;

endpackage
